// file: src/flash_ctrl_params.svh
// Named constants for the whole-array erase and suspend/resume controller.
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

// ==========================================================================
// Opcodes
`define OPC_ARRAY_ERASE_A 8'h60
`define OPC_ARRAY_ERASE_B 8'hC7
`define OPC_SUSPEND       8'h75
`define OPC_RESUME        8'h7A

// ==========================================================================
// Framing and widths
`define BITPOS_W     3
`define BITPOS_LAST  3'h7
`define BITPOS_ZERO  3'h0
`define BITPOS_ONE   3'h1
`define OPCNT_W      28
`define OPCNT_ONE    28'h0000001
`define OPCNT_ZERO   28'h0000000

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 10
`define RESUME_NS     200
`define RESUME_CYC    ((`RESUME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESCNT_W      8
`define RESCNT_ZERO   8'h00

`endif

// file: src/flash_ctrl_pkg.sv
// Types shared by the erase and suspend/resume controller.
`include "flash_ctrl_params.svh"
package flash_ctrl_pkg;
	// Self-timed operation currently owning the array.
	typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE, OP_CHIP} op_t;
	typedef logic [`OPCNT_W-1:0] opcnt_t;
endpackage : flash_ctrl_pkg

// file: src/flash_erase_suspend_ctrl.sv
// Whole-array erase, suspend and resume handling of a serial flash.
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_erase_suspend_ctrl #(
	parameter int unsigned PROG_US  = 500,
	parameter int unsigned ERASE_US = 50000,
	parameter int unsigned CHIP_US  = 2000000
) (
	// System clock and reset.
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Serial link from the host.
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	// Neighbouring command logic, same clock.
	input  wire logic wel_set,
	input  wire logic wel_clr,
	input  wire logic array_protected,
	input  wire logic prog_req,
	input  wire logic prog_conflict,
	input  wire logic erase_req,
	input  wire logic erase_conflict,
	input  wire logic wrsr_req,
	// Status.
	output logic      write_enable_latch,
	output logic      busy_flag,
	output logic      erase_suspend_flag,
	output logic      program_suspend_flag,
	output logic      array_erase_active,
	output logic      wrsr_go,
	output logic      op_done
);
	import flash_ctrl_pkg::*;

	// Self-timed lengths in system clock cycles. The operation counter is
	// wide enough for the longest default whole-array erase; a larger
	// figure would wrap silently, since the width is fixed at OPCNT_W bits.
	localparam int unsigned US_CYC = 1000 / `CLK_PERIOD_NS;
	localparam opcnt_t PROG_CYC  = opcnt_t'(PROG_US * US_CYC);
	localparam opcnt_t ERASE_CYC = opcnt_t'(ERASE_US * US_CYC);
	localparam opcnt_t CHIP_CYC  = opcnt_t'(CHIP_US * US_CYC);
	localparam logic [`RESCNT_W-1:0] RES_CYC = `RESCNT_W'(`RESUME_CYC);

	// ======================================================================
	// Link domain
	// The frame marker is forced high by chip select itself, so a frame
	// with no clocks leaves it set and the command words are never used.
	// This logic has no reset of its own: the first rise of chip select
	// presets the marker, and every frame then restarts the bit count on
	// its first clock. The command words below are read in the system
	// domain only after chip select has settled high, never mid-frame.
	logic                 fresh_q;
	logic [`BITPOS_W-1:0] bitpos_q;
	logic                 full_q;
	logic [6:0]           shift_q;
	logic [7:0]           opc_q;

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	// Bit count modulo eight and first byte; they hold still once clocks stop.
	always_ff @(posedge sck) begin
		if (fresh_q) begin
			bitpos_q <= `BITPOS_ONE;
			full_q   <= 1'b0;
			shift_q  <= {6'h00, mosi};
		end else begin
			bitpos_q <= bitpos_q + `BITPOS_ONE;
			shift_q  <= {shift_q[5:0], mosi};
			if (bitpos_q == `BITPOS_LAST && !full_q) begin
				opc_q  <= {shift_q, mosi}; // Later bytes are ignored.
				full_q <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Crossing into the system clock
	// Chip select and the frame marker each pass two flip-flops; a third
	// stage on chip select gives the rising edge that closes a frame.
	// The host keeps chip select high for several system cycles between
	// frames, so a short gap cannot be lost in the synchroniser.
	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic fr_s1_q, fr_s2_q;
	logic got_bits_q;
	logic frame_end;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			fr_s1_q <= 1'b1;
			fr_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			fr_s1_q <= fresh_q;
			fr_s2_q <= fr_s1_q;
		end
	end

	// Remember that this frame carried at least one clock.
	always_ff @(posedge ref_clk) begin
		if (!nrst || frame_end) begin
			got_bits_q <= 1'b0;
		end else if (!cs_s2_q && !fr_s2_q) begin
			got_bits_q <= 1'b1;
		end
	end

	// ======================================================================
	// Frame decode
	// The link words are quasi-static when the synchronised rise of chip
	// select is seen, since the host clock stands still between frames.
	// A frame shorter than one byte never fills the opcode, so it is
	// dropped here whatever stale word the link side still holds.
	logic opc_full, on_byte, cmd_erase, cmd_sus, cmd_res;
	assign frame_end = cs_s2_q && !cs_s3_q;
	assign opc_full  = frame_end && got_bits_q && full_q;
	assign on_byte   = bitpos_q == `BITPOS_ZERO;
	assign cmd_erase = opc_full && (opc_q == `OPC_ARRAY_ERASE_A ||
		opc_q == `OPC_ARRAY_ERASE_B);
	assign cmd_sus   = opc_full && on_byte && opc_q == `OPC_SUSPEND;
	assign cmd_res   = opc_full && on_byte && opc_q == `OPC_RESUME;

	// ======================================================================
	// Operation state
	op_t                  op_q;
	opcnt_t               run_q, prog_sav_q, erase_sav_q;
	logic                 wel_q, esus_q, psus_q, done_q, wrsr_q;
	logic [`RESCNT_W-1:0] res_q;
	// Registered mirrors of the owner decode, so status leaves a flip-flop.
	logic                 busy_q, chip_q;

	logic busy, any_sus, resuming, finish;
	assign busy     = op_q != OP_IDLE;
	assign any_sus  = esus_q || psus_q;
	assign resuming = res_q != `RESCNT_ZERO;
	assign finish   = busy && run_q == `OPCNT_ONE;

	// Array erase decisions.
	logic erase_bad, erase_prot, erase_go;
	assign erase_bad  = cmd_erase && !on_byte;
	assign erase_prot = cmd_erase && on_byte && wel_q && array_protected;
	assign erase_go   = cmd_erase && on_byte && wel_q && !array_protected &&
		!busy && !any_sus;

	// Suspend: chip erase and program under erase suspend are refused.
	// A suspend that lands while the resume window is still open is
	// dropped without a trace; the host must read the flags to know.
	logic sus_prog, sus_erase;
	assign sus_prog  = cmd_sus && op_q == OP_PROG && !esus_q && !resuming;
	assign sus_erase = cmd_sus && op_q == OP_ERASE && !resuming;

	// Resume regardless of the latch; a pending program goes first.
	logic res_ok, res_prog;
	assign res_ok   = cmd_res && !busy && any_sus;
	assign res_prog = res_ok && psus_q;

	// Requests from neighbouring command logic, taken only when the
	// frame decode is quiet in the same cycle.
	// A request that collides with a decoded frame is lost rather than
	// queued; the neighbour sees no latch change and may ask again.
	// Program outranks block erase, which outranks a status write.
	logic side_ok, prog_abort, prog_go, erase_abort, blk_go, wrsr_ok;
	assign side_ok     = !busy && !opc_full && wel_q;
	assign prog_abort  = side_ok && prog_req && esus_q && prog_conflict;
	assign prog_go     = side_ok && prog_req && !psus_q && !prog_abort;
	assign erase_abort = side_ok && erase_req && psus_q && erase_conflict;
	assign blk_go      = side_ok && erase_req && !esus_q && !erase_abort && !prog_req;
	assign wrsr_ok     = side_ok && wrsr_req && !any_sus && !prog_req && !erase_req;

	// Latch clears; a set in the same cycle wins.
	logic wel_drop, wel_d;
	assign wel_drop = erase_bad || erase_prot || erase_go || prog_abort ||
		erase_abort || prog_go || blk_go || wel_clr;
	assign wel_d    = wel_set ? 1'b1 : (wel_drop ? 1'b0 : wel_q);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wel_q <= 1'b0;
		end else begin
			wel_q <= wel_d;
		end
	end

	// Operation owner and its remaining time. The busy and whole-array
	// mirrors follow the owner in the same branches, so both status
	// outputs change on the same edge as the owner with no decode behind.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			op_q   <= OP_IDLE;
			run_q  <= `OPCNT_ZERO;
			busy_q <= 1'b0;
			chip_q <= 1'b0;
		end else if (erase_go) begin
			op_q   <= OP_CHIP;
			run_q  <= CHIP_CYC;
			busy_q <= 1'b1;
			chip_q <= 1'b1;
		end else if (sus_prog || sus_erase) begin
			op_q   <= OP_IDLE; // Ready while suspended.
			busy_q <= 1'b0;
		end else if (res_ok) begin
			op_q   <= res_prog ? OP_PROG : OP_ERASE;
			run_q  <= res_prog ? prog_sav_q : erase_sav_q;
			busy_q <= 1'b1;
		end else if (prog_go) begin
			op_q   <= OP_PROG;
			run_q  <= PROG_CYC;
			busy_q <= 1'b1;
		end else if (blk_go) begin
			op_q   <= OP_ERASE;
			run_q  <= ERASE_CYC;
			busy_q <= 1'b1;
		end else if (finish) begin
			op_q   <= OP_IDLE;
			run_q  <= `OPCNT_ZERO;
			busy_q <= 1'b0;
			chip_q <= 1'b0;
		end else if (busy) begin
			run_q <= run_q - `OPCNT_ONE;
		end
	end

	// Saved progress lets a resumed operation continue where it stopped.
	// Each kind keeps its own copy, so with both suspended the program
	// and the erase each pick up their own remaining time.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			prog_sav_q  <= `OPCNT_ZERO;
			erase_sav_q <= `OPCNT_ZERO;
		end else begin
			if (sus_prog) begin
				prog_sav_q <= run_q;
			end
			if (sus_erase) begin
				erase_sav_q <= run_q;
			end
		end
	end

	// Suspend flags. A suspend and a resume cannot meet in one cycle,
	// since a resume needs the array idle and a suspend needs it busy.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			esus_q <= 1'b0;
			psus_q <= 1'b0;
		end else begin
			if (sus_erase) begin
				esus_q <= 1'b1;
			end else if (res_ok && !res_prog) begin
				esus_q <= 1'b0;
			end
			if (sus_prog) begin
				psus_q <= 1'b1;
			end else if (res_prog) begin
				psus_q <= 1'b0;
			end
		end
	end

	// Resume settling window; a short figure keeps the host retry cheap.
	// Its length is a chosen figure, not a property of the array.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			res_q <= `RESCNT_ZERO;
		end else if (res_ok) begin
			res_q <= RES_CYC;
		end else if (resuming) begin
			res_q <= res_q - `RESCNT_W'(1);
		end
	end

	// Registered strobes; wrsr_go stays high while wrsr_req is held. Completion shows on the same edge as busy falls.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			done_q <= 1'b0;
			wrsr_q <= 1'b0;
		end else begin
			done_q <= finish;
			wrsr_q <= wrsr_ok;
		end
	end

	// ======================================================================
	// Outputs, each straight from a flip-flop.
	assign write_enable_latch   = wel_q;
	assign busy_flag            = busy_q;
	assign erase_suspend_flag   = esus_q;
	assign program_suspend_flag = psus_q;
	assign array_erase_active   = chip_q;
	assign wrsr_go              = wrsr_q;
	assign op_done              = done_q;
endmodule : flash_erase_suspend_ctrl
`default_nettype wire

// file: test/flash_ctrl_properties.sv
// Port-level assertions for the erase and suspend controller.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Checker
module flash_ctrl_checker (
	// Clock, reset and watched ports.
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wel_set,
	input wire logic prog_req,
	input wire logic prog_conflict,
	input wire logic wrsr_req,
	input wire logic write_enable_latch,
	input wire logic busy_flag,
	input wire logic erase_suspend_flag,
	input wire logic program_suspend_flag,
	input wire logic array_erase_active,
	input wire logic wrsr_go,
	input wire logic op_done
);
	// All checks sample the system clock and rest while reset is low.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_chip_busy: assert property (array_erase_active |-> busy_flag) else $error("idle erase");
	a_chip_unsuspended: assert property
		(array_erase_active |-> !erase_suspend_flag && !program_suspend_flag) else $error("suspended");
	a_chip_latch_low: assert property
		($rose(array_erase_active) |-> !write_enable_latch) else $error("latch kept");
	a_suspend_ready: assert property
		($rose(erase_suspend_flag) || $rose(program_suspend_flag) |-> !busy_flag) else $error("busy");
	a_resume_busy: assert property
		($fell(erase_suspend_flag) || $fell(program_suspend_flag) |-> busy_flag) else $error("idle");
	a_program_first: assert property
		($fell(erase_suspend_flag) |-> !program_suspend_flag) else $error("erase first");
	a_wrsr_refused: assert property
		(wrsr_req && (erase_suspend_flag || program_suspend_flag) |=> !wrsr_go) else $error("wrsr");
	a_conflict_abort: assert property
		(prog_req && prog_conflict && erase_suspend_flag && write_enable_latch && !busy_flag
		&& !wel_set |=> !write_enable_latch && !busy_flag) else $error("no abort");
	a_done_after_busy: assert property
		(op_done |-> $past(busy_flag) && !busy_flag) else $error("stray done");
endmodule : flash_ctrl_checker
bind flash_erase_suspend_ctrl flash_ctrl_checker chk (.ref_clk, .nrst, .wel_set, .prog_req,
	.prog_conflict, .wrsr_req, .write_enable_latch, .busy_flag, .erase_suspend_flag,
	.program_suspend_flag, .array_erase_active, .wrsr_go, .op_done);
`default_nettype wire

// file: test/host_link_model.sv
// Host side of the serial link: frames opcodes under chip select.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Link driver
module host_link_model (
	// Serial link toward the device.
	output var logic sck,
	output var logic cs_n,
	output var logic mosi
);
	// Idle link: clock low and stopped, device deselected.
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		mosi = 1'b1;
		#20 cs_n = 1'b1; // A clean rise presets the device's frame marker.
	end
	// Sends n bits MSB first; counts that are not a multiple of eight are used on purpose to break framing.
	task automatic frame(input logic [15:0] bits, input int n);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = bits[15-i];
			#62 sck = 1'b1;
			#63 sck = 1'b0;
		end
		#62 cs_n = 1'b1;
		mosi = ~mosi; // A released line must not keep showing its last bit.
		#500;
	endtask : frame
endmodule : host_link_model
`default_nettype wire

// file: test/test_serial_flash_erase_suspend_ctrl.sv
// Self-checking bench for the erase and suspend controller.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Bench
module test_serial_flash_erase_suspend_ctrl;
	logic ref_clk = 1'b0, nrst = 1'b0, wel_set = 1'b0, prog_req = 1'b0, erase_req = 1'b0;
	logic wrsr_req = 1'b0, array_protected = 1'b0, prog_conflict = 1'b0, wrsr_seen = 1'b0;
	logic erase_conflict = 1'b0;
	logic [31:0] seed = 32'h8B563E37;
	int fails = 0, samples_checked = 0;
	wire sck, cs_n, mosi, write_enable_latch, busy_flag, erase_suspend_flag;
	wire program_suspend_flag, wrsr_go;
	host_link_model host (.sck, .cs_n, .mosi);
	// Short self-timed counts keep the run brief.
	flash_erase_suspend_ctrl #(.PROG_US(3), .ERASE_US(4), .CHIP_US(3)) uut (.ref_clk, .nrst,
		.sck, .cs_n, .mosi, .wel_set, .wel_clr(1'b0), .array_protected, .prog_req,
		.prog_conflict, .erase_req, .erase_conflict, .wrsr_req, .write_enable_latch,
		.busy_flag, .erase_suspend_flag, .program_suspend_flag, .array_erase_active(),
		.wrsr_go, .op_done());
	// System clock and a sticky record of accepted status writes.
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wrsr_go) wrsr_seen <= 1'b1;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Expected status is {latch, busy, erase suspended, program suspended}.
	task automatic check(input logic [3:0] e);
		logic [4:0] got;
		got = {write_enable_latch, busy_flag, erase_suspend_flag, program_suspend_flag, wrsr_seen};
		samples_checked++;
		if (got !== {e, 1'b0}) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, {e, 1'b0});
		end
		wrsr_seen = 1'b0;
	endtask : check
	// Random trailing bits after the opcode must be ignored.
	task automatic cmd(input logic [7:0] op, input int n, input logic [3:0] e);
		seed = xs(seed);
		host.frame({op, seed[7:0]}, n);
		repeat (8) @(negedge ref_clk);
		check(e);
	endtask : cmd
	// Neighbour pulses {program, erase, status write, latch set}.
	task automatic req(input logic [3:0] r, input logic [3:0] e);
		@(negedge ref_clk);
		{prog_req, erase_req, wrsr_req, wel_set} = r;
		@(negedge ref_clk);
		{prog_req, erase_req, wrsr_req, wel_set} = 4'h0;
		repeat (2) @(negedge ref_clk);
		check(e);
	endtask : req
	task automatic wait_idle();
		for (int k = 0; k < 3000 && busy_flag !== 1'b0; k++) @(negedge ref_clk);
		if (busy_flag !== 1'b0) begin
			fails++;
			close_out();
		end
	endtask : wait_idle
	task automatic close_out();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// Main sequence: framing, protection, suspend and resume orders.
	initial begin
		repeat (8) @(negedge ref_clk);
		nrst = 1'b1;
		@(negedge ref_clk);
		cmd(8'h60, 16, 4'h0);
		cmd(8'h7A, 8, 4'h0);
		req(4'h1, 4'h8);
		array_protected = 1'b1;
		cmd(8'hC7, 8, 4'h0);
		array_protected = 1'b0;
		req(4'h1, 4'h8);
		cmd(8'h60, 12, 4'h0);
		for (int i = 0; i < 2; i++) begin
			req(4'h1, 4'h8);
			cmd(i ? 8'hC7 : 8'h60, 16, 4'h4);
			cmd(8'h75, 8, 4'h4);
			wait_idle();
			check(4'h0);
		end
		req(4'h1, 4'h8);
		req(4'h4, 4'h4);
		cmd(8'h75, 7, 4'h4);
		cmd(8'h75, 8, 4'h2);
		req(4'h1, 4'hA);
		req(4'h2, 4'hA);
		prog_conflict = 1'b1;
		req(4'h8, 4'h2);
		prog_conflict = 1'b0;
		cmd(8'h7A, 9, 4'h2);
		req(4'h1, 4'hA);
		req(4'h8, 4'h6);
		cmd(8'h75, 8, 4'h6);
		wait_idle();
		cmd(8'h7A, 8, 4'h4);
		wait_idle();
		req(4'h1, 4'h8);
		req(4'h8, 4'h4);
		cmd(8'h75, 8, 4'h1);
		req(4'h1, 4'h9);
		erase_conflict = 1'b1;
		req(4'h4, 4'h1);
		erase_conflict = 1'b0;
		req(4'h1, 4'h9);
		req(4'h4, 4'h5);
		cmd(8'h75, 8, 4'h3);
		cmd(8'h7A, 8, 4'h6);
		wait_idle();
		cmd(8'h7A, 8, 4'h4);
		wait_idle();
		check(4'h0);
		close_out();
	end
endmodule : test_serial_flash_erase_suspend_ctrl
`default_nettype wire
